/* File: rtl/afr_fault_recovery.sv */
// per-fault shutdown and recovery sequencer with attempt counting
`default_nettype none
module afr_fault_recovery
  import afr_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic fault_i, // synchronised fault level
  input wire logic manual_sel_i, // 1: wait for manual trigger
  input wire logic [1:0] limit_code_i, // automatic attempt limit code
  input wire logic manual_go_i, // one-cycle manual recovery pulse
  output logic shutdown_o // output held off by this fault
);
  afr_rcv_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [2:0] limit;
  logic spent;

  // next state: shut on fault, leave hold automatically or by trigger
  always_comb begin
    limit = afr_attempt_limit(limit_code_i);
    spent = (limit != 3'h0) && (cnt_q >= limit);
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      AFR_RCV_RUN: begin
        if (fault_i) begin
          state_d = AFR_RCV_HOLD;
        end
      end
      AFR_RCV_HOLD: begin
        if (!fault_i && manual_go_i && (manual_sel_i || spent)) begin
          state_d = AFR_RCV_RUN;
          cnt_d = 3'h0;
        end else if (!fault_i && !manual_sel_i && !spent) begin
          state_d = AFR_RCV_RUN;
          if (limit != 3'h0) begin
            cnt_d = 3'(cnt_q + 3'h1);
          end
        end
      end
      default: begin
        state_d = AFR_RCV_HOLD;
      end
    endcase
  end

  // register state and attempt count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= AFR_RCV_RUN;
      cnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign shutdown_o = (state_q == AFR_RCV_HOLD);

  a_shut_on_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_i |=> shutdown_o)
    else $error("fault did not shut the output");
  a_manual_hold_waits: assert property (@(posedge clk_i) disable iff (rst_i)
    (shutdown_o && manual_sel_i && !manual_go_i) |=> shutdown_o)
    else $error("manual recovery left hold without trigger");
  a_attempts_bounded: assert property (@(posedge clk_i) disable iff (rst_i)
    (shutdown_o && spent && !manual_go_i) |=> shutdown_o)
    else $error("recovered after attempt limit was spent");
endmodule
`default_nettype wire

/* File: rtl/afr_fault_regs.sv */
// fault status, battery threshold and recovery control registers on classic wishbone
`default_nettype none
module afr_fault_regs
  import afr_pkg::*;
(
  input wire logic clk_i, // system clock, 50 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic [7:0] batt_code_i, // sensed battery code
  input wire logic reg_uv_i, // regulator undervoltage level
  input wire logic overcurrent_flag_i, // amplifier overcurrent level
  input wire logic overtemp_i, // overtemperature fault level
  input wire logic overtemp_warn_i, // overtemperature warning level
  input wire logic clip_i, // clipping detected level
  input wire logic limiter_reducing_i, // limiter is lowering gain
  output logic amp_shutdown_o, // output stage held off
  output logic output_mute_o, // low-battery mute
  output logic limiter_enable_o, // limiter allowed to act
  output logic track_enable_o, // threshold follows battery
  output logic [1:0] thermal_attenuation_o // attenuation code in force
);
  logic [13:0] pin_s1_q, pin_s2_q;
  logic [7:0] batt_s;
  logic uv_s, oc_s, otf_s, otw_s, clip_s, lred_s;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [7:0] thr_q, thr_d;
  logic [7:0] lim_q, lim_d;
  logic [7:0] fctl_q, fctl_d;
  logic go_q, go_d;
  logic [7:0] stat_q, stat_d;
  logic shut_q, shut_d;
  logic mute_q, mute_d;
  logic lime_q, lime_d;
  logic trk_q, trk_d;
  logic [1:0] att_q, att_d;
  logic [2:0] fault_vec, sel_vec, shut_vec;
  logic req, wr_lane;
  logic [5:0] idx;

  // two-stage synchroniser for all pin levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 14'h0000;
      pin_s2_q <= 14'h0000;
    end else begin
      pin_s1_q <= {batt_code_i, reg_uv_i, overcurrent_flag_i, overtemp_i, overtemp_warn_i, clip_i,
                   limiter_reducing_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign {batt_s, uv_s, oc_s, otf_s, otw_s, clip_s, lred_s} = pin_s2_q;

  // bus request decode
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign idx = wb_adr_i[7:2];
  assign wr_lane = req && wb_we_i && wb_sel_i[0];

  // bus side next values: writes, read mux, manual trigger pulse
  always_comb begin
    ack_d = req;
    dat_d = 32'h0000_0000;
    thr_d = thr_q;
    lim_d = lim_q;
    fctl_d = fctl_q;
    go_d = 1'b0;
    if (req && !wb_we_i) begin
      case (idx)
        AFR_IDX_BATT: dat_d = {24'h00_0000, batt_s};
        AFR_IDX_LIMCTL: dat_d = {24'h00_0000, lim_q};
        AFR_IDX_THR: dat_d = {24'h00_0000, thr_q};
        AFR_IDX_STAT: dat_d = {24'h00_0000, stat_q};
        AFR_IDX_FCTL: dat_d = {24'h00_0000, fctl_q};
        default: dat_d = 32'h0000_0000;
      endcase
    end
    if (wr_lane) begin
      case (idx)
        AFR_IDX_LIMCTL: lim_d = wb_dat_i[7:0];
        AFR_IDX_THR: thr_d = wb_dat_i[7:0];
        AFR_IDX_FCTL: begin
          fctl_d = wb_dat_i[7:0];
          fctl_d[AFR_FC_MANUAL] = 1'b0; // write-only bit never stored
          go_d = wb_dat_i[AFR_FC_MANUAL];
        end
        default: begin
          go_d = 1'b0; // status and unmapped writes are dropped
        end
      endcase
    end
  end

  // register the bus side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      thr_q <= AFR_RST_THR;
      lim_q <= AFR_RST_LIMCTL;
      fctl_q <= AFR_RST_FCTL;
      go_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      thr_q <= thr_d;
      lim_q <= lim_d;
      fctl_q <= fctl_d;
      go_q <= go_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // one recovery sequencer per fault: undervoltage, overtemperature, overcurrent
  assign fault_vec = {uv_s, otf_s, oc_s};
  assign sel_vec = {fctl_q[AFR_FC_SEL_UV], fctl_q[AFR_FC_SEL_OT], fctl_q[AFR_FC_SEL_OC]};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_rcv
      afr_fault_recovery u_rcv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fault_i(fault_vec[g]),
        .manual_sel_i(sel_vec[g]),
        .limit_code_i(fctl_q[AFR_FC_LIMIT_LSB +: 2]),
        .manual_go_i(go_q),
        .shutdown_o(shut_vec[g])
      );
    end
  endgenerate

  // status flags and limiter-facing outputs
  always_comb begin
    stat_d = AFR_RST_STAT;
    stat_d[AFR_ST_RSV] = 1'b0;
    stat_d[AFR_ST_UV] = uv_s;
    stat_d[AFR_ST_ENG] = lred_s || (otw_s && (fctl_q[AFR_FC_ATTEN_LSB +: 2] != 2'h0));
    stat_d[AFR_ST_CLIP] = clip_s;
    stat_d[AFR_ST_OC] = oc_s;
    stat_d[AFR_ST_OTF] = otf_s;
    stat_d[AFR_ST_OTW] = otw_s;
    stat_d[AFR_ST_LOWB] = (batt_s <= thr_q);
    shut_d = |shut_vec;
    mute_d = (lim_q[AFR_LC_MODE_LSB +: 2] == AFR_MODE_MUTE_LOW) && (batt_s < thr_q);
    lime_d = (lim_q[AFR_LC_MODE_LSB +: 2] == AFR_MODE_ON) ||
             ((lim_q[AFR_LC_MODE_LSB +: 2] == AFR_MODE_ON_LOW) && (batt_s < thr_q));
    trk_d = lim_q[AFR_LC_TRACK];
    att_d = otw_s ? fctl_q[AFR_FC_ATTEN_LSB +: 2] : 2'h0;
  end

  // register status and outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= AFR_RST_STAT;
      shut_q <= 1'b0;
      mute_q <= 1'b0;
      lime_q <= 1'b0;
      trk_q <= 1'b0;
      att_q <= 2'h0;
    end else begin
      stat_q <= stat_d;
      shut_q <= shut_d;
      mute_q <= mute_d;
      lime_q <= lime_d;
      trk_q <= trk_d;
      att_q <= att_d;
    end
  end

  assign amp_shutdown_o = shut_q;
  assign output_mute_o = mute_q;
  assign limiter_enable_o = lime_q;
  assign track_enable_o = trk_q;
  assign thermal_attenuation_o = att_q;

  // bus handshake: every taken request gets a one-cycle ack, read data only with it
  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acked");
  a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data driven outside ack");

  // reset values, looked at on the first edge after reset falls
  a_fctl_reset_value: assert property (@(posedge clk_i)
    (!rst_i && $past(rst_i)) |-> (fctl_q == AFR_RST_FCTL && thr_q == AFR_RST_THR &&
    lim_q == AFR_RST_LIMCTL && stat_q == AFR_RST_STAT))
    else $error("control reset values wrong");

  // writes land in the addressed register only; the trigger bit is never stored
  a_thr_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lane && idx == AFR_IDX_THR) |=> (thr_q == $past(wb_dat_i[7:0])))
    else $error("threshold write did not land");
  a_thr_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_lane && idx == AFR_IDX_THR) |=> $stable(thr_q))
    else $error("threshold changed without a write");
  a_lim_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lane && idx == AFR_IDX_LIMCTL) |=> (lim_q == $past(wb_dat_i[7:0])))
    else $error("limiter control write did not land");
  a_lim_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_lane && idx == AFR_IDX_LIMCTL) |=> $stable(lim_q))
    else $error("limiter control changed without a write");
  a_fctl_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lane && idx == AFR_IDX_FCTL) |=> ({fctl_q[AFR_FC_ATTEN_LSB +: 2],
    fctl_q[AFR_FC_MANUAL - 1:0]} == $past({wb_dat_i[7:6], wb_dat_i[4:0]})))
    else $error("fault control write did not land");
  a_fctl_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_lane && idx == AFR_IDX_FCTL) |=> $stable(fctl_q))
    else $error("fault control changed without a write");
  a_manual_never_stored: assert property (@(posedge clk_i) disable iff (rst_i)
    !fctl_q[AFR_FC_MANUAL])
    else $error("trigger bit stored");
  a_go_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    go_q |=> !go_q)
    else $error("trigger pulse longer than one cycle");
  a_go_from_write: assert property (@(posedge clk_i) disable iff (rst_i)
    go_q |-> $past(wr_lane && idx == AFR_IDX_FCTL && wb_dat_i[AFR_FC_MANUAL]))
    else $error("trigger pulse without a trigger write");

  // read data carries the addressed register in lane 0 only
  a_status_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(!wb_we_i && idx == AFR_IDX_STAT)) |-> (wb_dat_o[31:7] == 25'h0))
    else $error("reserved status bits not zero");
  a_manual_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(!wb_we_i && idx == AFR_IDX_FCTL)) |-> !wb_dat_o[5])
    else $error("write-only trigger bit read as one");
  a_thr_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(!wb_we_i && idx == AFR_IDX_THR)) |->
    (wb_dat_o == {24'h00_0000, $past(thr_q)}))
    else $error("threshold read back wrong");
  a_batt_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(!wb_we_i && idx == AFR_IDX_BATT)) |->
    (wb_dat_o == {24'h00_0000, $past(batt_s)}))
    else $error("battery code read back wrong");

  // status flags follow the synchronised levels one edge later
  a_status_mirrors: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> ({stat_q[AFR_ST_UV], stat_q[AFR_ST_CLIP], stat_q[AFR_ST_OC],
    stat_q[AFR_ST_OTF], stat_q[AFR_ST_OTW]} == $past({uv_s, clip_s, oc_s, otf_s, otw_s})))
    else $error("status flags do not follow their inputs");
  a_uv_flag_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(uv_s) |=> stat_q[AFR_ST_UV])
    else $error("undervoltage flag late");
  a_low_batt_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (stat_q[AFR_ST_LOWB] == $past(batt_s <= thr_q)))
    else $error("low battery flag wrong");
  a_engaged_by_limiter: assert property (@(posedge clk_i) disable iff (rst_i)
    lred_s |=> stat_q[AFR_ST_ENG])
    else $error("engaged flag missing while limiter reduces");
  a_engaged_needs_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    (!lred_s && !otw_s) |=> !stat_q[AFR_ST_ENG])
    else $error("engaged flag without a cause");

  // limiter-facing outputs follow mode, threshold, warning and the sequencers
  a_mute_only_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    (lim_q[AFR_LC_MODE_LSB +: 2] != AFR_MODE_MUTE_LOW) |=> !output_mute_o)
    else $error("mute outside mute mode");
  a_mute_only_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (batt_s >= thr_q) |=> !output_mute_o)
    else $error("mute with battery not below threshold");
  a_limiter_off_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    (lim_q[AFR_LC_MODE_LSB +: 2] == AFR_MODE_OFF) |=> !limiter_enable_o)
    else $error("limiter enabled in off mode");
  a_limiter_low_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (lim_q[AFR_LC_MODE_LSB +: 2] == AFR_MODE_ON_LOW && batt_s >= thr_q)
    |=> !limiter_enable_o)
    else $error("limiter enabled above threshold");
  a_track_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (track_enable_o == $past(lim_q[AFR_LC_TRACK])))
    else $error("tracking output does not follow its bit");
  a_atten_needs_warn: assert property (@(posedge clk_i) disable iff (rst_i)
    !otw_s |=> (thermal_attenuation_o == 2'h0))
    else $error("attenuation without warning");
  a_atten_in_warn: assert property (@(posedge clk_i) disable iff (rst_i)
    otw_s |=> (thermal_attenuation_o == $past(fctl_q[AFR_FC_ATTEN_LSB +: 2])))
    else $error("attenuation code not applied in warning");
  a_oc_shuts_output: assert property (@(posedge clk_i) disable iff (rst_i)
    oc_s |-> ##2 amp_shutdown_o)
    else $error("overcurrent did not shut");
  a_shut_follows_seq: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (amp_shutdown_o == $past(|shut_vec)))
    else $error("shutdown output does not follow the sequencers");
endmodule
`default_nettype wire

/* File: rtl/afr_pkg.sv */
// constants, types and decode helpers shared by the fault-status register block
`default_nettype none
package afr_pkg;
  // register indexes; byte address on the bus is four times the index
  localparam logic [5:0] AFR_IDX_BATT = 6'h06;
  localparam logic [5:0] AFR_IDX_LIMCTL = 6'h07;
  localparam logic [5:0] AFR_IDX_THR = 6'h09;
  localparam logic [5:0] AFR_IDX_STAT = 6'h0A;
  localparam logic [5:0] AFR_IDX_FCTL = 6'h0B;

  // reset values
  localparam logic [7:0] AFR_RST_LIMCTL = 8'hA4;
  localparam logic [7:0] AFR_RST_THR = 8'h22;
  localparam logic [7:0] AFR_RST_STAT = 8'h00;
  localparam logic [7:0] AFR_RST_FCTL = 8'h18;

  // status bit positions
  localparam int AFR_ST_RSV = 7;
  localparam int AFR_ST_UV = 6;
  localparam int AFR_ST_ENG = 5;
  localparam int AFR_ST_CLIP = 4;
  localparam int AFR_ST_OC = 3;
  localparam int AFR_ST_OTF = 2;
  localparam int AFR_ST_OTW = 1;
  localparam int AFR_ST_LOWB = 0;

  // fault control field positions
  localparam int AFR_FC_ATTEN_LSB = 6;
  localparam int AFR_FC_MANUAL = 5;
  localparam int AFR_FC_LIMIT_LSB = 3;
  localparam int AFR_FC_SEL_UV = 2;
  localparam int AFR_FC_SEL_OT = 1;
  localparam int AFR_FC_SEL_OC = 0;

  // limiter control field positions
  localparam int AFR_LC_TRACK = 2;
  localparam int AFR_LC_MODE_LSB = 0;

  // limiter mode codes
  localparam logic [1:0] AFR_MODE_OFF = 2'h0;
  localparam logic [1:0] AFR_MODE_ON = 2'h1;
  localparam logic [1:0] AFR_MODE_MUTE_LOW = 2'h2;
  localparam logic [1:0] AFR_MODE_ON_LOW = 2'h3;

  // battery code scale: volts = base + span * code / full
  localparam real AFR_VBAT_BASE_V = 3.8;
  localparam real AFR_VBAT_SPAN_V = 12.4;
  localparam real AFR_VBAT_FULL_CODE = 255.0;

  // recovery state, one-hot
  typedef enum logic [1:0] {
    AFR_RCV_RUN = 2'b01,
    AFR_RCV_HOLD = 2'b10
  } afr_rcv_state_e;

  // attempt limit code to attempt count; code 3 maps to a count of zero, which means unlimited
  function automatic logic [2:0] afr_attempt_limit(input logic [1:0] code);
    case (code)
      2'h0: afr_attempt_limit = 3'h1;
      2'h1: afr_attempt_limit = 3'h3;
      2'h2: afr_attempt_limit = 3'h7;
      default: afr_attempt_limit = 3'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: verif/test_afr_fault_regs.sv */
// self-checking bench for the fault status, threshold and recovery register block
`default_nettype none
module test_afr_fault_regs
  import afr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [7:0] batt = 8'hff;
  logic [5:0] pins = 6'h00; // {uv, reducing, clip, oc, overtemp, warning}
  logic [31:0] dat_o;
  logic ack;
  logic shut;
  logic mute;
  logic limiter_mode_select;
  logic track;
  logic [1:0] atten;
  logic [31:0] rd;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int fidx [3] = '{2, 1, 5}; // fault pin per select bit: oc, overtemp, uv

  afr_fault_regs i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(dat_o),
    .wb_ack_o(ack),
    .batt_code_i(batt),
    .reg_uv_i(pins[5]),
    .overcurrent_flag_i(pins[2]),
    .overtemp_i(pins[1]),
    .overtemp_warn_i(pins[0]),
    .clip_i(pins[3]),
    .limiter_reducing_i(pins[4]),
    .amp_shutdown_o(shut),
    .output_mute_o(mute),
    .limiter_enable_o(limiter_mode_select),
    .track_enable_o(track),
    .thermal_attenuation_o(atten)
  );

  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic wishbone cycle, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'h1, rd);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, 4'h1, rd);
    check(name, rd, exp);
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // raise one fault pin, drop it, then look at the shutdown level
  task automatic pulse(input int k, input logic held);
    pins[k] <= 1'b1;
    cyc_wait(6);
    check("shutdown raised", shut, 1'b1);
    pins[k] <= 1'b0;
    cyc_wait(8);
    check("shutdown after fault", shut, held);
  endtask

  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("threshold reset", 8'h24, 32'h0000_0022);
    rdchk("status reset", 8'h28, 32'h0000_0000);
    rdchk("fault ctrl reset", 8'h2c, 32'h0000_0018);
    rdchk("limiter ctrl reset", 8'h1c, 32'h0000_00a4);
    check("track at reset", track, 1'b1);
    wr(8'h24, 32'h0000_005a);
    xfer(1'b1, 8'h24, 32'h0000_0011, 4'h0, rd); // lane 0 not selected
    rdchk("threshold rw", 8'h24, 32'h0000_005a);
    wr(8'h28, 32'h0000_00ff);
    wr(8'h3c, 32'h0000_00ff);
    rdchk("status ignores write", 8'h28, 32'h0000_0000);
    rdchk("unmapped read", 8'h3c, 32'h0000_0000);
    // each status input alone reaches its own flag
    for (int k = 0; k < 6; k++) begin
      pins <= 6'(6'h01 << k);
      cyc_wait(4);
      rdchk("status flag", 8'h28, 32'(8'h02 << k));
      pins <= 6'h00;
      cyc_wait(12);
    end
    // battery compare against the threshold
    batt <= 8'h5a;
    cyc_wait(4);
    rdchk("battery code", 8'h18, 32'h0000_005a);
    rdchk("low battery at threshold", 8'h28, 32'h0000_0001);
    batt <= 8'h5b;
    cyc_wait(4);
    rdchk("battery above threshold", 8'h28, 32'h0000_0000);
    // limiter modes, battery below then equal to threshold
    for (int m = 0; m < 8; m++) begin
      batt <= (m < 4) ? 8'h40 : 8'h5a;
      wr(8'h1c, 32'(m % 4));
      cyc_wait(4);
      check("mute", mute, (m % 4 == 2) && (m < 4));
      check("limiter enable", limiter_mode_select, (m % 4 == 1) || ((m % 4 == 3) && (m < 4)));
      check("track off", track, 1'b0);
    end
    wr(8'h1c, 32'h0000_0004);
    cyc_wait(4);
    check("track on", track, 1'b1);
    // thermal warning attenuation codes
    batt <= 8'hff;
    pins <= 6'h01;
    for (int c = 0; c < 4; c++) begin
      wr(8'h2c, 32'h0000_0018 | 32'(c << 6));
      cyc_wait(4);
      check("attenuation", 32'(atten), 32'(c));
      rdchk("fault ctrl", 8'h2c, 32'h0000_0018 | 32'(c << 6));
      rdchk("engaged by warning", 8'h28, (c == 0) ? 32'h0000_0002 : 32'h0000_0022);
    end
    pins <= 6'h00;
    cyc_wait(4);
    check("attenuation idle", 32'(atten), 32'h0000_0000);
    // automatic attempt limits 1, 3, 7, then manual release
    for (int c = 0; c < 3; c++) begin
      wr(8'h2c, 32'h0000_0020 | 32'(c << 3));
      rdchk("trigger reads zero", 8'h2c, 32'(c << 3));
      for (int n = 0; n < (2 << c) - 1; n++) pulse(2, 1'b0);
      pulse(2, 1'b1);
      wr(8'h2c, 32'h0000_0020 | 32'(c << 3));
      cyc_wait(6);
      check("manual release", shut, 1'b0);
    end
    // unlimited attempts
    wr(8'h2c, 32'h0000_0018);
    repeat (8) pulse(2, 1'b0);
    // per-fault manual recovery select
    for (int s = 0; s < 3; s++) begin
      wr(8'h2c, 32'(8'h18 | (8'h01 << s)));
      pulse(fidx[s], 1'b1);
      wr(8'h2c, 32'(8'h38 | (8'h01 << s)));
      cyc_wait(6);
      check("manual recovery", shut, 1'b0);
    end
    // reset in mid-run releases a held fault and restores the control registers
    wr(8'h24, 32'h0000_0077);
    wr(8'h2c, 32'h0000_0019);
    pulse(2, 1'b1);
    rst_i <= 1'b1;
    cyc_wait(3);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("shutdown after reset", shut, 1'b0);
    rdchk("threshold after reset", 8'h24, 32'h0000_0022);
    rdchk("fault ctrl after reset", 8'h2c, 32'h0000_0018);
    rdchk("limiter ctrl after reset", 8'h1c, 32'h0000_00a4);
    report_and_stop();
  end
endmodule
`default_nettype wire
